// ### design/dmiu_pkg.sv
// Package with constants, encodings and register map of the data-move instruction unit
package dmiu_pkg;

    // Widths of the core's datapath
    localparam int DATA_W     = 8;     // Byte-wide data path
    localparam int PTR_W      = 16;    // Pointer width
    localparam int INSTR_W    = 14;    // One program word
    localparam int MEM_DEPTH  = 128;   // Bytes of file-register storage
    localparam int MEM_AW     = 7;     // Address width of that storage

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_INSTR    = 8'h00;  // Write executes one program word
    localparam logic [7:0] OFS_ACC      = 8'h04;  // Working register
    localparam logic [7:0] OFS_BANK     = 8'h08;  // Bank select register
    localparam logic [7:0] OFS_PROG_COUNTER_HIGH_LATCH   = 8'h0c;  // Program counter high latch
    localparam logic [7:0] OFS_FSP0     = 8'h10;  // File-select pointer 0
    localparam logic [7:0] OFS_FSP1     = 8'h14;  // File-select pointer 1
    localparam logic [7:0] OFS_STATUS   = 8'h18;  // Status flags
    localparam logic [7:0] OFS_MEM_ADDR = 8'h1c;  // Address for the memory window
    localparam logic [7:0] OFS_MEM_DATA = 8'h20;  // Data at that address
    localparam logic [7:0] OFS_LAST_OP  = 8'h24;  // Last executed opcode class

    // Status bit positions
    localparam int ST_Z  = 2;  // Zero
    localparam int ST_DC = 1;  // Digit carry
    localparam int ST_C  = 0;  // Carry

    // Opcode field of a program word: bits 13..10
    localparam int OP_HI = 13;
    localparam int OP_LO = 10;
    localparam logic [3:0] OPC_LIT_ACC   = 4'h1;  // Operand bits 7..0
    localparam logic [3:0] OPC_BANK_LIT  = 4'h2;  // Operand bits 4..0
    localparam logic [3:0] OPC_PLATCH    = 4'h3;  // Operand bits 6..0
    localparam logic [3:0] OPC_ACC_FILE  = 4'h4;  // Operand bits 6..0
    localparam logic [3:0] OPC_IND_LOAD  = 4'h5;  // Bit 2 pointer, bits 1..0 mode

    // Pointer update modes
    localparam logic [1:0] PUM_PRE_INC  = 2'h0;
    localparam logic [1:0] PUM_PRE_DEC  = 2'h1;
    localparam logic [1:0] PUM_POST_INC = 2'h2;
    localparam logic [1:0] PUM_POST_DEC = 2'h3;

    // File addresses of the two indirect windows
    localparam logic [6:0] IND_WIN0 = 7'h00;
    localparam logic [6:0] IND_WIN1 = 7'h01;

    // Reset values
    localparam logic [7:0]  RST_ACC    = 8'h00;
    localparam logic [4:0]  RST_BANK   = 5'h00;
    localparam logic [6:0]  RST_PROG_COUNTER_HIGH_LATCH = 7'h00;
    localparam logic [15:0] RST_FSP    = 16'h0000;
    localparam logic [2:0]  RST_STATUS = 3'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Classes reported for the last executed word
    typedef enum logic [2:0] {
        DMIU_NONE     = 3'h0,
        DMIU_LIT_ACC  = 3'h1,
        DMIU_BANK     = 3'h3,
        DMIU_PLATCH   = 3'h2,
        DMIU_ACC_FILE = 3'h6,
        DMIU_IND_LOAD = 3'h7,
        DMIU_ILLEGAL  = 3'h5
    } dmiu_op_t;

endpackage

// ### design/dmiu_top.sv
// Data-move instruction unit with an AXI4-Lite register slave
//
// Overview of operation
// - Indirect load copies pointed byte, sets zero only
// - Mode field selects pre/post increment or decrement
// - Indirect window redirects to pointer address, unstored
// - Pointers are 16 bits and wrap around
// - Bank literal loads 5 bits, flags untouched
// - Latch literal loads 7 bits, flags untouched
// - Literal loads 8 bits into accumulator, flags untouched
// - Store writes accumulator to addressed file register
// - Pointer stepping never touches any status flag
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module dmiu_top (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // Architectural state
    logic [7:0]             acc;          // Working register
    logic [4:0]             bank_select_reg;
    logic [6:0]             prog_counter_high_latch;
    logic [15:0]            file_select_pointer [2];
    logic [2:0]             status;       // Z, DC, C
    logic [6:0]             mem_addr;     // Software window address
    logic [7:0]             file_mem [dmiu_pkg::MEM_DEPTH];
    dmiu_pkg::dmiu_op_t     last_op;

    // Write channel holding registers
    logic                   aw_held;      // Address captured
    logic                   w_held;       // Data captured
    logic [7:0]             aw_addr_q;
    logic [31:0]            w_data_q;
    logic [3:0]             w_strb_q;
    logic                   do_wr;        // Both halves present and no answer pending: act this cycle

    // Decoded program word
    logic [13:0]            instr;
    logic [3:0]             opc;
    logic                   ptr_sel;
    logic [1:0]             pointer_update_mode;
    logic                   exec;         // A program word executes this cycle
    logic                   indirect_load_op;
    logic                   bank_literal_op;
    logic                   prog_latch_literal_op;
    logic                   literal_to_acc_op;
    logic                   acc_to_file_op;
    logic [15:0]            ptr_cur;      // Selected pointer before update
    logic [15:0]            ptr_step;     // Pointer plus or minus one
    logic [15:0]            ind_eaddr;    // Address the indirect load reads
    logic [7:0]             ind_data;     // Byte the indirect load fetches
    logic [6:0]             store_addr;   // Resolved store target

    // Redirect an access to an indirect window onto its pointer
    function automatic logic [6:0] resolve_addr(input logic [6:0] a,
                                                input logic [15:0] p0,
                                                input logic [15:0] p1);
        logic [6:0] r;
        r = a;
        if (a == dmiu_pkg::IND_WIN0) begin
            r = p0[6:0];
        end else if (a == dmiu_pkg::IND_WIN1) begin
            r = p1[6:0];
        end
        return r;
    endfunction

    // Read a byte; the window addresses read as zero, whatever storage holds there
    function automatic logic [7:0] fetch(input logic [6:0] a,
                                         input logic [7:0] d);
        logic [7:0] r;
        r = d;
        if (a == dmiu_pkg::IND_WIN0 || a == dmiu_pkg::IND_WIN1) begin
            r = 8'h00;
        end
        return r;
    endfunction

    // Merge a byte lane write into an existing value
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = nw[7:0];
        end
        if (strb[1]) begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction

    // Bus write is acted upon once both halves have been captured
    assign do_wr = aw_held && w_held && !s_axi_bvalid;

    // Ready while the matching half is not yet held; the read address while no read answer is pending
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    // Decode of the word written into the instruction register
    assign instr                 = w_data_q[13:0];
    assign opc                   = instr[dmiu_pkg::OP_HI:dmiu_pkg::OP_LO];
    assign ptr_sel               = instr[2];
    assign pointer_update_mode   = instr[1:0];
    assign exec                  = do_wr && (aw_addr_q == dmiu_pkg::OFS_INSTR)
                                   && (w_strb_q[1:0] == 2'h3);
    assign indirect_load_op      = exec && (opc == dmiu_pkg::OPC_IND_LOAD);
    assign bank_literal_op       = exec && (opc == dmiu_pkg::OPC_BANK_LIT);
    assign prog_latch_literal_op = exec && (opc == dmiu_pkg::OPC_PLATCH);
    assign literal_to_acc_op     = exec && (opc == dmiu_pkg::OPC_LIT_ACC);
    assign acc_to_file_op        = exec && (opc == dmiu_pkg::OPC_ACC_FILE);

    // Pointer arithmetic wraps naturally in 16 bits
    assign ptr_cur  = file_select_pointer[ptr_sel];
    assign ptr_step = pointer_update_mode[0] ? 16'(ptr_cur - 16'h0001)
                                             : 16'(ptr_cur + 16'h0001);

    // Pre modes read at the stepped value, post modes at the old one
    always_comb begin
        unique case (pointer_update_mode)
            dmiu_pkg::PUM_PRE_INC,
            dmiu_pkg::PUM_PRE_DEC:  ind_eaddr = ptr_step;
            dmiu_pkg::PUM_POST_INC,
            dmiu_pkg::PUM_POST_DEC: ind_eaddr = ptr_cur;
        endcase
    end

    // Only the low address bits reach storage; upper pointer bits alias
    assign ind_data   = fetch(ind_eaddr[6:0], file_mem[ind_eaddr[6:0]]);
    assign store_addr = resolve_addr(instr[6:0], file_select_pointer[0],
                                     file_select_pointer[1]);

    // Write address capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held   <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held   <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        end else if (do_wr) begin
            aw_held   <= 1'b0;
        end
    end

    // Write data capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held   <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held   <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_wr) begin
            w_held   <= 1'b0;
        end
    end

    // Write response; unmapped offsets answer with an error
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dmiu_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q > dmiu_pkg::OFS_MEM_DATA) ?
                            dmiu_pkg::RESP_SLVERR : dmiu_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Working register: literal load, indirect load or software write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= dmiu_pkg::RST_ACC;
        end else if (literal_to_acc_op) begin
            acc <= instr[7:0];
        end else if (indirect_load_op) begin
            acc <= ind_data;
        end else if (do_wr && aw_addr_q == dmiu_pkg::OFS_ACC && w_strb_q[0]) begin
            acc <= w_data_q[7:0];
        end
    end

    // Bank select: literal load only, readable by software
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_select_reg <= dmiu_pkg::RST_BANK;
        end else if (bank_literal_op) begin
            bank_select_reg <= instr[4:0];
        end
    end

    // Program counter high latch: literal load only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_counter_high_latch <= dmiu_pkg::RST_PROG_COUNTER_HIGH_LATCH;
        end else if (prog_latch_literal_op) begin
            prog_counter_high_latch <= instr[6:0];
        end
    end

    // Pointers: stepped by indirect loads, written by software
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_select_pointer[0] <= dmiu_pkg::RST_FSP;
            file_select_pointer[1] <= dmiu_pkg::RST_FSP;
        end else if (indirect_load_op) begin
            file_select_pointer[ptr_sel] <= ptr_step;
        end else if (do_wr && aw_addr_q == dmiu_pkg::OFS_FSP0) begin
            file_select_pointer[0] <= merge16(file_select_pointer[0], w_data_q, w_strb_q);
        end else if (do_wr && aw_addr_q == dmiu_pkg::OFS_FSP1) begin
            file_select_pointer[1] <= merge16(file_select_pointer[1], w_data_q, w_strb_q);
        end
    end

    // Status: only the zero flag follows an indirect load
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= dmiu_pkg::RST_STATUS;
        end else if (indirect_load_op) begin
            status[dmiu_pkg::ST_Z] <= (ind_data == 8'h00);
        end else if (do_wr && aw_addr_q == dmiu_pkg::OFS_STATUS && w_strb_q[0]) begin
            status <= w_data_q[2:0];
        end
    end

    // Software memory window address
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr <= 7'h00;
        end else if (do_wr && aw_addr_q == dmiu_pkg::OFS_MEM_ADDR && w_strb_q[0]) begin
            mem_addr <= w_data_q[6:0];
        end
    end

    // File storage; no reset, as in a real register file RAM
    // Window addresses are resolved first, so they reach storage only when the pointer's low bits hold 0 or 1
    always_ff @(posedge core_clk) begin
        if (acc_to_file_op) begin
            file_mem[store_addr] <= acc;
        end else if (do_wr && aw_addr_q == dmiu_pkg::OFS_MEM_DATA && w_strb_q[0]) begin
            file_mem[resolve_addr(mem_addr, file_select_pointer[0],
                                  file_select_pointer[1])] <= w_data_q[7:0];
        end
    end

    // Record of the last executed word, for software to observe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_op <= dmiu_pkg::DMIU_NONE;
        end else if (exec) begin
            unique case (opc)
                dmiu_pkg::OPC_LIT_ACC:  last_op <= dmiu_pkg::DMIU_LIT_ACC;
                dmiu_pkg::OPC_BANK_LIT: last_op <= dmiu_pkg::DMIU_BANK;
                dmiu_pkg::OPC_PLATCH:   last_op <= dmiu_pkg::DMIU_PLATCH;
                dmiu_pkg::OPC_ACC_FILE: last_op <= dmiu_pkg::DMIU_ACC_FILE;
                dmiu_pkg::OPC_IND_LOAD: last_op <= dmiu_pkg::DMIU_IND_LOAD;
                default:                last_op <= dmiu_pkg::DMIU_ILLEGAL;
            endcase
        end
    end

    // Read channel: data registered one cycle after the address is taken
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= dmiu_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= dmiu_pkg::RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                dmiu_pkg::OFS_INSTR:    s_axi_rdata <= {18'h0, w_data_q[13:0]};
                dmiu_pkg::OFS_ACC:      s_axi_rdata <= {24'h0, acc};
                dmiu_pkg::OFS_BANK:     s_axi_rdata <= {27'h0, bank_select_reg};
                dmiu_pkg::OFS_PROG_COUNTER_HIGH_LATCH:   s_axi_rdata <= {25'h0, prog_counter_high_latch};
                dmiu_pkg::OFS_FSP0:     s_axi_rdata <= {16'h0, file_select_pointer[0]};
                dmiu_pkg::OFS_FSP1:     s_axi_rdata <= {16'h0, file_select_pointer[1]};
                dmiu_pkg::OFS_STATUS:   s_axi_rdata <= {29'h0, status};
                dmiu_pkg::OFS_MEM_ADDR: s_axi_rdata <= {25'h0, mem_addr};
                dmiu_pkg::OFS_MEM_DATA: begin
                    // Window addresses read through their pointers
                    s_axi_rdata <= {24'h0, file_mem[resolve_addr(mem_addr,
                                   file_select_pointer[0], file_select_pointer[1])]};
                end
                dmiu_pkg::OFS_LAST_OP:  s_axi_rdata <= {29'h0, last_op};
                default: begin
                    // Unmapped offset reads zero with an error
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= dmiu_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ### dv/dmiu_monitor.sv
// Checker of the register bus timing of the data-move unit
`timescale 1ns/100ps
module dmiu_monitor (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // One clock domain, reset disables every check
    default clocking mon_cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // A word executes one edge after both halves are taken; the answer is seen one edge later
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer missing");
    // A lone address stays parked until its data arrives
    a_aw_parked: assert property (s_axi_awvalid && s_axi_awready && !s_axi_wvalid
        |=> !s_axi_awready) else $error("address not held");
    // A lone data beat stays parked until its address arrives
    a_w_parked: assert property (s_axi_wvalid && s_axi_wready && !s_axi_awvalid
        |=> !s_axi_wready) else $error("data not held");
    // Read data follows the address by one edge
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer missing");
    // Responses stand until taken
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    // Only one read in flight
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    // A refused read carries no data
    a_err_nodata: assert property (s_axi_rvalid && s_axi_rresp == dmiu_pkg::RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("error read with data");
    // A taken response is gone on the next edge
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid lingers");
endmodule

bind dmiu_top dmiu_monitor dmiu_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ### dv/dmiu_tb_top.sv
// Self-checking testbench of the data-move instruction unit
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module data_move_instruction_unit_tb_top;
    logic core_clk = 1'b0, rst_n = 1'b0;  // Clock and reset
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, eb;
    logic [33:0] er;
    logic [1:0] wq[$];   // Expected write responses
    logic [33:0] rq[$];  // Expected {rresp, rdata}
    int n_errors = 0, cmp_count = 0, seed;
    // Reference state of the unit
    logic [7:0] acc, b, mem[128];
    logic [15:0] p, np, eff;
    logic [2:0] st;

    always #4 core_clk = ~core_clk;

    dmiu_top dmiu_top_i (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    // Watch the response channels at mid-cycle, where everything has settled
    always @(negedge core_clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            eb = wq.pop_front();
            `CHK(s_axi_bresp, eb)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            er = rq.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, er)
        end
    end

    // Bus write; lag 1 offers data late, lag 2 the address late
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                      input int lag);
        bit pa, pw, ga, gw, gb;
        int t;
        @(posedge core_clk);
        wq.push_back(r);
        pa = (lag == 2);
        pw = (lag == 1);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= !pa;
        s_axi_wvalid <= !pw;
        // Late offers also take the answer late, so a response must stand
        s_axi_bready <= (lag == 0);
        for (t = 0; t < 60; t++) begin
            @(negedge core_clk);
            ga = s_axi_awvalid && s_axi_awready;
            gw = s_axi_wvalid && s_axi_wready;
            gb = s_axi_bvalid && s_axi_bready;
            @(posedge core_clk);
            if (ga || pa) s_axi_awvalid <= pa;
            if (gw || pw) s_axi_wvalid <= pw;
            pa = 0;
            pw = 0;
            if (gb) break;
            if (t == 3) s_axi_bready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        if (t == 60) begin
            n_errors++;
            wrap_up();
        end
    endtask

    // Bus read with its expected answer noted first
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        bit ga, gr, lr;
        int t;
        @(posedge core_clk);
        rq.push_back(e);
        lr = $urandom_range(1);  // Randomly take the data late
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !lr;
        for (t = 0; t < 60; t++) begin
            @(negedge core_clk);
            ga = s_axi_arvalid && s_axi_arready;
            gr = s_axi_rvalid && s_axi_rready;
            @(posedge core_clk);
            if (ga) s_axi_arvalid <= 1'b0;
            if (gr) break;
            if (t == 1 && lr) s_axi_rready <= 1'b1;
        end
        s_axi_rready <= 1'b0;
        if (t == 60) begin
            n_errors++;
            wrap_up();
        end
    endtask

    // Short forms: checked register read, one program word, core state
    task automatic rchk(input logic [7:0] a, input logic [31:0] v);
        rd(a, {dmiu_pkg::RESP_OKAY, v});
    endtask
    task automatic ex(input logic [3:0] op, input logic [9:0] arg);
        wr(dmiu_pkg::OFS_INSTR, {18'h0, op, arg}, dmiu_pkg::RESP_OKAY, $urandom_range(2));
    endtask
    task automatic core();
        rchk(dmiu_pkg::OFS_ACC, {24'h0, acc});
        rchk(dmiu_pkg::OFS_STATUS, {29'h0, st});
    endtask

    task automatic wrap_up();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Cut a hang short well past the expected run length
    initial begin
        #(8 * 30000);
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        seed = $urandom(59);
        acc = 8'h0;
        st = 3'h0;
        // Reset values, including both pointers
        rchk(dmiu_pkg::OFS_BANK, 32'h0);
        rchk(dmiu_pkg::OFS_PROG_COUNTER_HIGH_LATCH, 32'h0);
        rchk(dmiu_pkg::OFS_LAST_OP, 32'h0);
        rchk(dmiu_pkg::OFS_FSP0, 32'h0);
        rchk(dmiu_pkg::OFS_FSP1, 32'h0);
        core();
        // Literals keep all flags; bank and latch keep only their width
        st = 3'h7;
        wr(dmiu_pkg::OFS_STATUS, 32'h7, dmiu_pkg::RESP_OKAY, 0);
        for (int k = 0; k < 3; k++) begin
            // All ones last, so the bank is known to be full later on
            acc = (k == 2) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
            ex(dmiu_pkg::OPC_LIT_ACC, {2'h3, acc});
            ex(dmiu_pkg::OPC_BANK_LIT, {2'h3, acc});
            ex(dmiu_pkg::OPC_PLATCH, {2'h3, acc});
            rchk(dmiu_pkg::OFS_BANK, {27'h0, acc[4:0]});
            rchk(dmiu_pkg::OFS_PROG_COUNTER_HIGH_LATCH, {25'h0, acc[6:0]});
            core();
        end
        // Fill the file storage beyond the two windows
        for (int a = 2; a < 128; a++) begin
            mem[a] = (a == 9) ? 8'h0 : 8'($urandom);
            wr(dmiu_pkg::OFS_MEM_ADDR, a, dmiu_pkg::RESP_OKAY, 0);
            wr(dmiu_pkg::OFS_MEM_DATA, {24'h0, mem[a]}, dmiu_pkg::RESP_OKAY, 0);
        end
        // Store to the top address, then through window 1
        acc = 8'($urandom);
        ex(dmiu_pkg::OPC_LIT_ACC, {2'h0, acc});
        ex(dmiu_pkg::OPC_ACC_FILE, 10'h7f);
        mem[127] = acc;
        wr(dmiu_pkg::OFS_FSP1, 32'h1285, dmiu_pkg::RESP_OKAY, 0);
        ex(dmiu_pkg::OPC_ACC_FILE, 10'h01);
        mem[5] = acc;
        wr(dmiu_pkg::OFS_MEM_ADDR, 32'h5, dmiu_pkg::RESP_OKAY, 1);
        rchk(dmiu_pkg::OFS_MEM_DATA, {24'h0, mem[5]});
        wr(dmiu_pkg::OFS_MEM_ADDR, 32'h7f, dmiu_pkg::RESP_OKAY, 2);
        rchk(dmiu_pkg::OFS_MEM_ADDR, 32'h7f);
        rchk(dmiu_pkg::OFS_MEM_DATA, {24'h0, mem[127]});
        rchk(dmiu_pkg::OFS_FSP1, 32'h1285);
        core();
        // Indirect loads: every mode, both pointers, wrap and random starts
        st = 3'h3;
        wr(dmiu_pkg::OFS_STATUS, 32'h3, dmiu_pkg::RESP_OKAY, 0);
        for (int pass = 0; pass < 2; pass++)
            for (int n = 0; n < 2; n++)
                for (int m = 0; m < 4; m++) begin
                    p = pass ? 16'($urandom) : (m[0] ? 16'h0000 : 16'hffff);
                    np = m[0] ? p - 16'h1 : p + 16'h1;
                    eff = m[1] ? p : np;
                    b = (eff[6:0] < 7'h2) ? 8'h0 : mem[eff[6:0]];
                    acc = b;
                    st[2] = (b == 8'h0);
                    wr(n ? dmiu_pkg::OFS_FSP1 : dmiu_pkg::OFS_FSP0, {16'h0, p},
                       dmiu_pkg::RESP_OKAY, 0);
                    ex(dmiu_pkg::OPC_IND_LOAD, {7'h0, n[0], m[1:0]});
                    rchk(n ? dmiu_pkg::OFS_FSP1 : dmiu_pkg::OFS_FSP0, {16'h0, np});
                    core();
                end
        // Refused and read-only places, then an unknown opcode
        wr(8'h28, 32'h0, dmiu_pkg::RESP_SLVERR, 0);
        rd(8'h28, {dmiu_pkg::RESP_SLVERR, 32'h0});
        wr(dmiu_pkg::OFS_BANK, 32'h0, dmiu_pkg::RESP_OKAY, 0);
        rchk(dmiu_pkg::OFS_BANK, {27'h0, 5'h1f});
        ex(4'hf, 10'h3ff);
        rchk(dmiu_pkg::OFS_LAST_OP, {29'h0, dmiu_pkg::DMIU_ILLEGAL});
        rchk(dmiu_pkg::OFS_INSTR, 32'h3fff);
        core();
        repeat (4) @(posedge core_clk);
        wrap_up();
    end
endmodule
